/* File: rtl/cace_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cace_defines.svh"
// What this block does
// - Add source to destination, sum to destination, opcodes 02 to 06
// - Add is two's-complement binary, source location left untouched
// - Add sets carry on carry out of bit 7, else clears
// - Add sets zero for all-zero result, sign for negative result
// - Add sets overflow when same-sign operands give opposite-sign result
// - Add clears decimal-adjust, sets half-carry on low nibble carry
// - AND stores bitwise AND of source and destination, source unchanged
// - AND: zero on zero result, sign is bit 7, overflow cleared, others kept
// - Call pushes low then high return byte, then loads target, no flags
// - Pushed return address is the address after the call instruction
// - Return pops two stack bytes back into the program counter
// - Complement carry EF, 1 byte, 4 cycles, only carry inverted
// - Flags register sits at register-file address D5
// - Clear writes zero, B0 direct or B1 indirect, 2 bytes, 4 cycles, no flags
module cace_exec
	import cace_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

cace_state_t state_q;
logic [7:0] rf_q [0:255];
logic [23:0] instr_q, instr_d;
logic [7:0] op, b1, b2, wr_hi, wr_lo, dst_a, src_a, dv, sv, res;
logic [7:0] sp_q, flags_q, rfa_q, wa, wstrb_m0, waddr_q;
logic [31:0] wdata_q, wm;
logic [3:0] wstrb_q, cnt_q, cyc_q, blen_q;
logic [15:0] pc_q, pc_ret, tgt, pc_wr;
logic [8:0] sum9;
logic [4:0] sumh;
logic [6:0] dec_i, dec_q;
logic [1:0] len_q;
logic is_add, is_and, is_clr, is_call, is_ret, is_ccf, commit, idle, go;
logic aw_got_q, w_got_q, wr_en, illegal_q, ovf, wmap, rmap;
logic [31:0] rd_val;

function automatic logic [6:0] dec(input logic [7:0] o);
	if ((o[7:4] == `CACE_GRP_ADD || o[7:4] == `CACE_GRP_AND) && o[3:0] == `CACE_M_RR)
		dec = {1'b1, `CACE_LEN2, `CACE_CYC_SHORT};
	else if ((o[7:4] == `CACE_GRP_ADD || o[7:4] == `CACE_GRP_AND) && o[3:0] == `CACE_M_RIR)
		dec = {1'b1, `CACE_LEN2, `CACE_CYC_LONG};
	else if ((o[7:4] == `CACE_GRP_ADD || o[7:4] == `CACE_GRP_AND) && o[3:0] >= `CACE_M_R
		&& o[3:0] <= `CACE_M_IM)
		dec = {1'b1, `CACE_LEN3, `CACE_CYC_LONG};
	else if (o == `CACE_OP_CALL_DA)
		dec = {1'b1, `CACE_LEN3, `CACE_CYC_CALL_DA};
	else if (o == `CACE_OP_CALL_IRR)
		dec = {1'b1, `CACE_LEN2, `CACE_CYC_CALL_IRR};
	else if (o == `CACE_OP_RET)
		dec = {1'b1, `CACE_LEN1, `CACE_CYC_RET};
	else if (o == `CACE_OP_CCF)
		dec = {1'b1, `CACE_LEN1, `CACE_CYC_SHORT};
	else if (o == `CACE_OP_CLR_R || o == `CACE_OP_CLR_IR)
		dec = {1'b1, `CACE_LEN2, `CACE_CYC_SHORT};
	else
		dec = 7'h00;
endfunction : dec

// Flags register overlays its register-file address
function automatic logic [7:0] rfr(input logic [7:0] a);
	rfr = (a == `CACE_FLAGS_ADDR) ? flags_q : rf_q[a];
endfunction : rfr

////////////////////////////////////////////////////////////////////////////////
// Operand decode
assign op = instr_q[7:0];
assign b1 = instr_q[15:8];
assign b2 = instr_q[23:16];
assign wr_hi = {`CACE_WR_BASE, b1[7:4]};
assign wr_lo = {`CACE_WR_BASE, b1[3:0]};
assign is_add = op[7:4] == `CACE_GRP_ADD && op[3:0] >= `CACE_M_RR && op[3:0] <= `CACE_M_IM;
assign is_and = op[7:4] == `CACE_GRP_AND && op[3:0] >= `CACE_M_RR && op[3:0] <= `CACE_M_IM;
assign is_clr = op == `CACE_OP_CLR_R || op == `CACE_OP_CLR_IR;
assign is_call = op == `CACE_OP_CALL_DA || op == `CACE_OP_CALL_IRR;
assign is_ret = op == `CACE_OP_RET;
assign is_ccf = op == `CACE_OP_CCF;

always_comb
begin
	dst_a = b1;
	src_a = b1;
	case (op[3:0])
		`CACE_M_RR:
		begin
			dst_a = wr_hi;
			src_a = wr_lo;
		end
		`CACE_M_RIR:
		begin
			dst_a = wr_hi;
			src_a = rfr(wr_lo);
		end
		`CACE_M_R: dst_a = b2;
		`CACE_M_RI:
		begin
			dst_a = b2;
			src_a = rfr(b1);
		end
		default: dst_a = b1;
	endcase
	if (op == `CACE_OP_CLR_IR)
		dst_a = rfr(b1);
end

assign dv = rfr(dst_a);
assign sv = (op[3:0] == `CACE_M_IM) ? b2 : rfr(src_a);
assign sum9 = {1'b0, dv} + {1'b0, sv};
assign sumh = {1'b0, dv[3:0]} + {1'b0, sv[3:0]};
assign ovf = (dv[7] == sv[7]) && (sum9[7] != dv[7]);
assign res = is_add ? sum9[7:0] : (dv & sv);
assign pc_ret = pc_q + {14'h0000, len_q};
assign tgt = (op == `CACE_OP_CALL_DA) ? {b1, b2} : {rfr(b1), rfr(b1 + `CACE_SP_STEP)};
assign commit = state_q == CACE_COMMIT;
assign idle = state_q == CACE_IDLE;

////////////////////////////////////////////////////////////////////////////////
// Bus write side
assign wr_en = aw_got_q && w_got_q && !s_axi_bvalid;
assign wa = waddr_q;
assign wm = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
assign wstrb_m0 = wm[7:0];
assign instr_d = (instr_q & ~wm[23:0]) | (wdata_q[23:0] & wm[23:0]);
assign pc_wr = (pc_q & ~wm[15:0]) | (wdata_q[15:0] & wm[15:0]);
assign dec_i = dec(instr_d[7:0]);
assign go = wr_en && wa == `CACE_A_INSTR && idle && dec_i[6];
assign wmap = wa == `CACE_A_INSTR || wa == `CACE_A_STAT || wa == `CACE_A_PC
	|| wa == `CACE_A_SP || wa == `CACE_A_RFA || wa == `CACE_A_RFD;

always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CACE_RESP_OKAY;
		aw_got_q <= 1'b0;
		w_got_q <= 1'b0;
		waddr_q <= 8'h00;
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_q <= 1'b1;
			s_axi_awready <= 1'b0;
			waddr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_q <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		if (wr_en)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wmap ? `CACE_RESP_OKAY : `CACE_RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Bus read side
assign rmap = s_axi_araddr == `CACE_A_INSTR || s_axi_araddr == `CACE_A_STAT
	|| s_axi_araddr == `CACE_A_PC || s_axi_araddr == `CACE_A_SP
	|| s_axi_araddr == `CACE_A_RFA || s_axi_araddr == `CACE_A_RFD;

always_comb
begin
	rd_val = 32'h00000000;
	case (s_axi_araddr)
		`CACE_A_INSTR: rd_val = {8'h00, instr_q};
		`CACE_A_STAT: rd_val = {16'h0000, flags_q, 6'h00, illegal_q, !idle};
		`CACE_A_PC: rd_val = {16'h0000, pc_q};
		`CACE_A_SP: rd_val = {24'h000000, sp_q};
		`CACE_A_RFA: rd_val = {24'h000000, rfa_q};
		`CACE_A_RFD: rd_val = {24'h000000, rfr(rfa_q)};
		default: rd_val = 32'h00000000;
	endcase
end

always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `CACE_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= rd_val;
		s_axi_rresp <= rmap ? `CACE_RESP_OKAY : `CACE_RESP_SLVERR;
	end
	else if (s_axi_rvalid && s_axi_rready)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer: busy for exactly the instruction's cycle count
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		state_q <= CACE_IDLE;
		cnt_q <= 4'h0;
		cyc_q <= 4'h0;
		len_q <= 2'h0;
		dec_q <= 7'h00;
		instr_q <= 24'h000000;
		illegal_q <= 1'b0;
	end
	else
	case (state_q)
		CACE_IDLE:
		if (wr_en && wa == `CACE_A_INSTR)
		begin
			instr_q <= instr_d;
			illegal_q <= !dec_i[6];
			if (go)
			begin
				state_q <= CACE_EXEC;
				dec_q <= dec_i;
				len_q <= dec_i[5:4];
				cyc_q <= dec_i[3:0];
				cnt_q <= dec_i[3:0] - `CACE_CYC_ADJ;
			end
		end
		CACE_EXEC:
		if (cnt_q == 4'h0)
			state_q <= CACE_COMMIT;
		else
			cnt_q <= cnt_q - 4'h1;
		CACE_COMMIT: state_q <= CACE_IDLE;
		default: state_q <= CACE_IDLE;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Flags, written in the commit cycle with the destination
always_ff @(posedge aclk)
begin
	if (!aresetn)
		flags_q <= `CACE_FLAGS_RST;
	else if (commit && is_add)
	begin
		flags_q[`CACE_FC] <= sum9[8];
		flags_q[`CACE_FZ] <= res == 8'h00;
		flags_q[`CACE_FS] <= res[7];
		flags_q[`CACE_FV] <= ovf;
		flags_q[`CACE_FD] <= 1'b0;
		flags_q[`CACE_FH] <= sumh[4];
	end
	else if (commit && is_and)
	begin
		flags_q[`CACE_FZ] <= res == 8'h00;
		flags_q[`CACE_FS] <= res[7];
		flags_q[`CACE_FV] <= 1'b0;
	end
	else if (commit && is_ccf)
		flags_q[`CACE_FC] <= !flags_q[`CACE_FC];
	else if (commit && is_clr && dst_a == `CACE_FLAGS_ADDR)
		flags_q <= 8'h00;
	else if (wr_en && idle && wa == `CACE_A_RFD && rfa_q == `CACE_FLAGS_ADDR && wstrb_q[0])
		flags_q <= wdata_q[7:0];
end

////////////////////////////////////////////////////////////////////////////////
// Register file and stack
always_ff @(posedge aclk)
begin
	if (commit && (is_add || is_and || is_clr) && dst_a != `CACE_FLAGS_ADDR)
		rf_q[dst_a] <= is_clr ? 8'h00 : res;
	if (commit && is_call)
	begin
		rf_q[sp_q - `CACE_SP_STEP] <= pc_ret[7:0];
		rf_q[sp_q - `CACE_SP_STEP - `CACE_SP_STEP] <= pc_ret[15:8];
	end
	if (wr_en && idle && wa == `CACE_A_RFD && rfa_q != `CACE_FLAGS_ADDR)
		rf_q[rfa_q] <= (rf_q[rfa_q] & ~wstrb_m0) | (wdata_q[7:0] & wstrb_m0);
end

always_ff @(posedge aclk)
begin
	if (!aresetn)
		rfa_q <= 8'h00;
	else if (wr_en && wa == `CACE_A_RFA && wstrb_q[0])
		rfa_q <= wdata_q[7:0];
end

////////////////////////////////////////////////////////////////////////////////
// Program counter and stack pointer
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		pc_q <= `CACE_PC_RST;
		sp_q <= `CACE_SP_RST;
	end
	else if (commit)
	begin
		if (is_call)
		begin
			pc_q <= tgt;
			sp_q <= sp_q - `CACE_SP_STEP - `CACE_SP_STEP;
		end
		else if (is_ret)
		begin
			pc_q <= {rfr(sp_q), rfr(sp_q + `CACE_SP_STEP)};
			sp_q <= sp_q + `CACE_SP_STEP + `CACE_SP_STEP;
		end
		else
			pc_q <= pc_ret;
	end
	else if (wr_en && idle && wa == `CACE_A_PC)
		pc_q <= pc_wr;
	else if (wr_en && idle && wa == `CACE_A_SP && wstrb_q[0])
		sp_q <= wdata_q[7:0];
end

////////////////////////////////////////////////////////////////////////////////
// Checks
always_ff @(posedge aclk)
begin
	if (!aresetn || go)
		blen_q <= 4'h1;
	else if (state_q == CACE_EXEC)
		blen_q <= blen_q + 4'h1;
end

a_busy_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
	commit |-> blen_q == cyc_q && cyc_q == dec_q[3:0])
	else $error("busy time differs from cycle count");
a_add_sum: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_add && dst_a != `CACE_FLAGS_ADDR |=> rf_q[$past(dst_a)] == $past(dv + sv))
	else $error("add result wrong");
a_add_carry: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_add |=> flags_q[`CACE_FC] == $past(sum9[8]) && idle)
	else $error("add carry wrong");
a_add_zs: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_add |=> flags_q[`CACE_FZ] == ($past(res) == 8'h00) && flags_q[`CACE_FS] == $past(res[7]))
	else $error("add zero or sign wrong");
a_add_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_add |=> flags_q[`CACE_FV] == ($past(dv[7]) == $past(sv[7]) && $past(res[7]) != $past(dv[7])))
	else $error("add overflow wrong");
a_add_dh: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_add |=> !flags_q[`CACE_FD] && flags_q[`CACE_FH] == $past(sumh[4]))
	else $error("add decimal or half carry wrong");
a_and_flags: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_and |=> !flags_q[`CACE_FV] && flags_q[`CACE_FC] == $past(flags_q[`CACE_FC])
		&& flags_q[`CACE_FH] == $past(flags_q[`CACE_FH]) && flags_q[`CACE_FD] == $past(flags_q[`CACE_FD]))
	else $error("and flags wrong");
a_call_push: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_call |=> sp_q == $past(sp_q) - 8'h02 && rf_q[sp_q] == $past(pc_ret[15:8])
		&& rf_q[sp_q + 8'h01] == $past(pc_ret[7:0]) && flags_q == $past(flags_q))
	else $error("call push wrong");
a_ccf_flip: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_ccf |=> flags_q == ($past(flags_q) ^ 8'h80))
	else $error("carry complement wrong");
a_clr_zero: assert property (@(posedge aclk) disable iff (!aresetn)
	commit && is_clr && dst_a != `CACE_FLAGS_ADDR |=> rf_q[$past(dst_a)] == 8'h00 && $stable(flags_q))
	else $error("clear wrong");

endmodule : cace_exec
`default_nettype wire

/* File: rtl/cace_defines.svh */
`ifndef CACE_DEFINES_SVH
`define CACE_DEFINES_SVH
// Opcode groups and low-nibble addressing modes
`define CACE_GRP_ADD 4'h0
`define CACE_GRP_AND 4'h5
`define CACE_M_RR 4'h2
`define CACE_M_RIR 4'h3
`define CACE_M_R 4'h4
`define CACE_M_RI 4'h5
`define CACE_M_IM 4'h6
`define CACE_OP_CALL_DA 8'hf6
`define CACE_OP_CALL_IRR 8'hf4
`define CACE_OP_RET 8'haf
`define CACE_OP_CCF 8'hef
`define CACE_OP_CLR_R 8'hb0
`define CACE_OP_CLR_IR 8'hb1
// Lengths and cycle counts
`define CACE_LEN1 2'h1
`define CACE_LEN2 2'h2
`define CACE_LEN3 2'h3
`define CACE_CYC_SHORT 4'h4
`define CACE_CYC_LONG 4'h6
`define CACE_CYC_CALL_DA 4'he
`define CACE_CYC_CALL_IRR 4'hc
`define CACE_CYC_RET 4'h8
`define CACE_CYC_ADJ 4'h2
// Flag bit positions
`define CACE_FC 3'h7
`define CACE_FZ 3'h6
`define CACE_FS 3'h5
`define CACE_FV 3'h4
`define CACE_FD 3'h3
`define CACE_FH 3'h2
// Register file map
`define CACE_FLAGS_ADDR 8'hd5
`define CACE_WR_BASE 4'hc
`define CACE_SP_STEP 8'h01
`define CACE_PC_RST 16'h0000
`define CACE_SP_RST 8'h00
`define CACE_FLAGS_RST 8'h00
// Bus register offsets
`define CACE_A_INSTR 8'h00
`define CACE_A_STAT 8'h04
`define CACE_A_PC 8'h08
`define CACE_A_SP 8'h0c
`define CACE_A_RFA 8'h10
`define CACE_A_RFD 8'h14
`define CACE_RESP_OKAY 2'h0
`define CACE_RESP_SLVERR 2'h2
`endif

/* File: rtl/cace_pkg.sv */
`default_nettype none
package cace_pkg;
	typedef enum logic [1:0] {
		CACE_IDLE = 2'h0,
		CACE_EXEC = 2'h1,
		CACE_COMMIT = 2'h3
	} cace_state_t;
endpackage : cace_pkg
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cace_defines.svh"
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [31:0] cyc = 32'h0;
	int num_errors = 0;
	int compares = 0;
	cace_exec dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	initial
	begin
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 32'h1;
	////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic tout();
		$display("BAD timeout exp done got hang");
		num_errors++;
		test_done();
	endtask : tout
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	////////////////////////////////////////////////////////////////////////
	// Bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) tout();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) tout();
	endtask : rd
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask : wreg
	task automatic ck_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, e, d);
	endtask : ck_reg
	task automatic setr(input logic [7:0] a, input logic [7:0] d);
		wreg(`CACE_A_RFA, {24'h0, a});
		wreg(`CACE_A_RFD, {24'h0, d});
	endtask : setr
	task automatic ck_rf(input string nm, input logic [7:0] a, input logic [7:0] e);
		wreg(`CACE_A_RFA, {24'h0, a});
		ck_reg(nm, `CACE_A_RFD, {24'h0, e});
	endtask : ck_rf
	task automatic exec(input logic [23:0] ins, input int n);
		logic [31:0] d;
		logic [1:0] r;
		logic [31:0] t0;
		int k;
		int e;
		wr(`CACE_A_INSTR, {8'h00, ins}, r);
		t0 = cyc;
		d = 32'h1;
		k = 0;
		while (d[0] !== 1'b0 && k < 50)
		begin
			rd(`CACE_A_STAT, d, r);
			k++;
		end
		if (k >= 50) tout();
		e = int'(cyc - t0);
		chk("busy cycles", 32'h1, {31'h0, (e >= n - 1) && (e <= n + 3)});
	endtask : exec
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		ck_reg("pc", `CACE_A_PC, 32'h0);
		ck_reg("sp", `CACE_A_SP, 32'h0);
		ck_reg("status", `CACE_A_STAT, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_add();
		setr(8'hc1, 8'h12);
		setr(8'hc2, 8'h03);
		setr(`CACE_FLAGS_ADDR, 8'h08);
		exec(24'h001202, 4);
		ck_rf("add rr dst", 8'hc1, 8'h15);
		ck_rf("add rr src", 8'hc2, 8'h03);
		ck_rf("add rr flags", `CACE_FLAGS_ADDR, 8'h00);
		wreg(`CACE_A_PC, 32'h0100);
		setr(8'h30, 8'h7f);
		exec(24'h013006, 6);
		ck_rf("add im dst", 8'h30, 8'h80);
		ck_reg("add im status", `CACE_A_STAT, 32'h3400);
		ck_reg("add im pc", `CACE_A_PC, 32'h0103);
		setr(8'h31, 8'h01);
		setr(8'h30, 8'hff);
		exec(24'h303104, 6);
		ck_rf("add r dst", 8'h30, 8'h00);
		ck_rf("add r flags", `CACE_FLAGS_ADDR, 8'hc4);
		setr(8'h03, 8'h0a);
		exec(24'h001203, 6);
		ck_rf("add ir dst", 8'hc1, 8'h1f);
		ck_rf("add ir flags", `CACE_FLAGS_ADDR, 8'h00);
		setr(8'h32, 8'h31);
		exec(24'h303205, 6);
		ck_rf("add ri dst", 8'h30, 8'h01);
		$display("test add done");
	endtask : t_add
	task automatic t_and();
		setr(`CACE_FLAGS_ADDR, 8'h9c);
		setr(8'h30, 8'hf0);
		exec(24'h803056, 6);
		ck_rf("and im dst", 8'h30, 8'h80);
		ck_rf("and im flags", `CACE_FLAGS_ADDR, 8'hac);
		exec(24'h001252, 4);
		ck_rf("and rr dst", 8'hc1, 8'h03);
		ck_rf("and rr src", 8'hc2, 8'h03);
		ck_rf("and rr flags", `CACE_FLAGS_ADDR, 8'h8c);
		exec(24'h303154, 6);
		ck_rf("and r dst", 8'h30, 8'h00);
		ck_reg("and r status", `CACE_A_STAT, 32'hcc00);
		$display("test and done");
	endtask : t_and
	task automatic t_ccf_clr();
		wreg(`CACE_A_PC, 32'h0200);
		exec(24'h0000ef, 4);
		ck_rf("ccf flags", `CACE_FLAGS_ADDR, 8'h4c);
		ck_reg("ccf pc", `CACE_A_PC, 32'h0201);
		exec(24'h0000ef, 4);
		ck_reg("ccf status", `CACE_A_STAT, 32'hcc00);
		setr(8'h30, 8'h5e);
		exec(24'h0030b0, 4);
		ck_rf("clr dst", 8'h30, 8'h00);
		ck_reg("clr pc", `CACE_A_PC, 32'h0204);
		setr(8'h32, 8'h77);
		setr(8'h31, 8'h32);
		exec(24'h0031b1, 4);
		ck_rf("clr ir dst", 8'h32, 8'h00);
		ck_rf("clr ir ptr", 8'h31, 8'h32);
		ck_rf("clr flags", `CACE_FLAGS_ADDR, 8'hcc);
		$display("test ccf clr done");
	endtask : t_ccf_clr
	task automatic t_call();
		wreg(`CACE_A_PC, 32'h1a47);
		wreg(`CACE_A_SP, 32'h00b2);
		exec(24'h2115f6, 14);
		ck_reg("call pc", `CACE_A_PC, 32'h1521);
		ck_reg("call sp", `CACE_A_SP, 32'h00b0);
		ck_rf("call low", 8'hb1, 8'h4a);
		ck_rf("call high", 8'hb0, 8'h1a);
		ck_rf("call flags", `CACE_FLAGS_ADDR, 8'hcc);
		exec(24'h0000af, 8);
		ck_reg("ret pc", `CACE_A_PC, 32'h1a4a);
		ck_reg("ret sp", `CACE_A_SP, 32'h00b2);
		wreg(`CACE_A_PC, 32'h1a47);
		setr(8'hc0, 8'h15);
		setr(8'hc1, 8'h21);
		exec(24'h00c0f4, 12);
		ck_reg("icall pc", `CACE_A_PC, 32'h1521);
		ck_rf("icall low", 8'hb1, 8'h49);
		ck_rf("icall high", 8'hb0, 8'h1a);
		$display("test call done");
	endtask : t_call
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		rd(8'h18, d, r);
		chk("unmapped rresp", {30'h0, `CACE_RESP_SLVERR}, {30'h0, r});
		chk("unmapped rdata", 32'h0, d);
		wr(8'h05, 32'hff, r);
		chk("unmapped bresp", {30'h0, `CACE_RESP_SLVERR}, {30'h0, r});
		$display("test bus done");
	endtask : t_bus
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_add();
		t_and();
		t_ccf_clr();
		t_call();
		t_bus();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
